// >>> bench/test_ush_core.sv
`timescale 1ns/10ps
module test_ush_core;
    import ush_pkg::*;
    logic        clk, rst_n, cyc, stb, we, go, irm, so_bad;
    logic [3:0]  sel, wsel;
    logic [31:0] adr, wdat, rdat, q;
    logic [7:0]  sb;
    logic        ack, sin, irin, sout, irout_n, irq, busy;
    int          fails, n_compared, cyc_cnt, n;

    ush_core dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .serial_in(sin), .ir_in(irin),
        .serial_out(sout), .ir_out_n(irout_n), .irq(irq));
    ush_remote rem (.clk(clk), .ir_mode(irm), .send(go), .sbyte(sb),
        .tx_line(sout), .tx_ir_n(irout_n), .rx_line(sin), .rx_ir(irin), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (irm && sout !== 1'b1) so_bad <= 1'b1;
        if (cyc_cnt == 20000) begin
            fails++;
            results();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        sel  <= wsel;
        adr  <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic poll(input logic [31:0] a, input int b);
        logic [31:0] r;
        r = 32'h0;
        while (r[b] !== 1'b1) wb(1'b0, a, 32'h0, r);
    endtask

    task automatic send_byte(input logic [7:0] b);
        sb <= b;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (busy) @(posedge clk);
    endtask

    task automatic wait_got(input int k);
        while (rem.got.size() < k) @(posedge clk);
    endtask

    task automatic t_reset;
        wb(1'b0, SHADOW_WINDOW_11, 32'h0, q);
        chk(q, 32'h00000000, "window reset");
        wsel = 4'hE;
        wb(1'b1, SHADOW_WINDOW_11, 32'h00000077, q);
        wsel = 4'hF;
        wb(1'b0, LINE_STAT_ADDR, 32'h0, q);
        chk(q, 32'h00000020, "status reset");
        wb(1'b0, 32'h50001194, 32'h0, q);
        chk(q, RD_UNMAPPED, "unmapped");
        chk(irq, 1'b0, "irq reset");
        $display("t_reset done");
    endtask

    task automatic t_rx_plain;
        wb(1'b1, INT_EN_ADDR, 32'h00000001, q);
        send_byte(8'hA5);
        while (irq !== 1'b1) @(posedge clk);
        wb(1'b0, LINE_STAT_ADDR, 32'h0, q);
        chk(q[0], 1'b1, "ready");
        wb(1'b0, SHADOW_WINDOW_12, 32'h0, q);
        chk(q, 32'h000000A5, "rx byte");
        wb(1'b1, INT_CLR_ADDR, 32'h00000007, q);
        wb(1'b1, INT_EN_ADDR, 32'h00000000, q);
        wb(1'b0, INT_STAT_ADDR, 32'h0, q);
        chk(q, 32'h00000000, "status cleared");
        chk(irq, 1'b0, "irq cleared");
        $display("t_rx_plain done");
    endtask

    task automatic t_overrun;
        send_byte(8'h11);
        send_byte(8'h22);
        poll(INT_STAT_ADDR, EV_OVR_BIT);
        chk(irq, 1'b0, "irq masked");
        wb(1'b0, LINE_STAT_ADDR, 32'h0, q);
        chk(q[1:0], 2'b11, "overrun");
        wb(1'b0, SHADOW_WINDOW_11, 32'h0, q);
        chk(q, 32'h00000022, "overwritten");
        wb(1'b1, INT_CLR_ADDR, 32'h00000007, q);
        $display("t_overrun done");
    endtask

    task automatic t_tx_plain;
        rem.got.delete();
        wb(1'b1, SHADOW_WINDOW_11, 32'hA5A5FF3C, q);
        poll(LINE_STAT_ADDR, LS_TRANSMIT_HOLDING_EMPTY_FLAG_BIT);
        wb(1'b1, SHADOW_WINDOW_11, 32'h0000005A, q);
        wb(1'b0, LINE_STAT_ADDR, 32'h0, q);
        chk(q[5], 1'b0, "empty cleared");
        wb(1'b1, SHADOW_WINDOW_12, 32'h000000C3, q);
        wait_got(2);
        chk(rem.got[0], 8'h3C, "tx first");
        chk(rem.got[1], 8'hC3, "tx replaced");
        $display("t_tx_plain done");
    endtask

    task automatic t_fifo_tx;
        rem.got.delete();
        wb(1'b1, FIFO_CTRL_ADDR, 32'h00000001, q);
        n = 0;
        q = 32'h0;
        while (q[6] !== 1'b1) begin
            wb(1'b1, SHADOW_WINDOW_12, 32'h00000040 + n, q);
            n++;
            wb(1'b0, LINE_STAT_ADDR, 32'h0, q);
        end
        chk(n, FIFO_DEPTH + 1, "tx depth");
        wb(1'b1, SHADOW_WINDOW_12, 32'h000000EE, q);
        wait_got(n);
        repeat (200) @(posedge clk);
        chk(rem.got.size(), n, "tx count");
        for (int i = 0; i < n; i++) chk(rem.got[i], 8'h40 + i, "tx order");
        $display("t_fifo_tx done");
    endtask

    task automatic t_fifo_rx;
        for (int i = 0; i < 17; i++) send_byte(8'h80 + i);
        poll(INT_STAT_ADDR, EV_OVR_BIT);
        wb(1'b0, LINE_STAT_ADDR, 32'h0, q);
        chk(q[1:0], 2'b11, "fifo overrun");
        for (int i = 0; i < 16; i++) begin
            wb(1'b0, SHADOW_WINDOW_11, 32'h0, q);
            chk(q, 32'h00000080 + i, "fifo pop");
        end
        wb(1'b0, LINE_STAT_ADDR, 32'h0, q);
        chk(q[0], 1'b0, "fifo empty");
        $display("t_fifo_rx done");
    endtask

    task automatic t_ir;
        rem.got.delete();
        wb(1'b1, FIFO_CTRL_ADDR, 32'h00000002, q);
        irm <= 1'b1;
        send_byte(8'h6B);
        poll(LINE_STAT_ADDR, LS_DR_BIT);
        wb(1'b0, SHADOW_WINDOW_11, 32'h0, q);
        chk(q, 32'h0000006B, "ir rx");
        wb(1'b1, SHADOW_WINDOW_11, 32'h00000096, q);
        wait_got(1);
        chk(rem.got[0], 8'h96, "ir tx");
        chk(so_bad, 1'b0, "serial idle");
        $display("t_ir done");
    endtask

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        rst_n   = 1'b0;
        {cyc, stb, we, go, irm, so_bad} = 6'h00;
        sel     = 4'hF;
        wsel    = 4'hF;
        adr     = 32'h0;
        wdat    = 32'h0;
        sb      = 8'h00;
        cyc_cnt = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_rx_plain();
        t_overrun();
        t_tx_plain();
        t_fifo_tx();
        t_fifo_rx();
        t_ir();
        results();
    end
endmodule

// >>> bench/ush_remote.sv
`timescale 1ns/10ps
// Far-end UART: 1 start, 8 data LSB first, 1 stop, 16 clocks per bit
module ush_remote (
    input  wire logic       clk,
    input  wire logic       ir_mode,
    input  wire logic       send,
    input  wire logic [7:0] sbyte,
    input  wire logic       tx_line,
    input  wire logic       tx_ir_n,
    output logic            rx_line,
    output logic            rx_ir,
    output logic            busy
);
    logic [7:0] got[$];
    logic       line;
    logic [9:0] fr;
    logic [7:0] sh;
    logic       mon;

    // Unused input stays at the idle mark level
    assign rx_line = ir_mode ? 1'b1 : line;
    assign rx_ir   = ir_mode ? line : 1'b1;
    assign mon     = ir_mode ? tx_ir_n : tx_line;

    initial begin
        line = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (send) begin
                busy <= 1'b1;
                fr = {1'b1, sbyte, 1'b0};
                for (int i = 0; i < 10; i++) begin
                    line <= fr[i];
                    repeat (16) @(posedge clk);
                end
                busy <= 1'b0;
            end
        end
    end

    // Sample each bit in its middle
    initial forever begin
        @(posedge clk);
        if (mon === 1'b0) begin
            repeat (8) @(posedge clk);
            for (int j = 0; j < 8; j++) begin
                repeat (16) @(posedge clk);
                sh[j] = mon;
            end
            repeat (16) @(posedge clk);
            got.push_back(sh);
        end
    end
endmodule

// >>> hw/ush_core.sv
`timescale 1ns/10ps
// Behaviour
// - Shadow windows alias receive and transmit data
// - Read low byte returns received character
// - Non-FIFO unread byte overwritten, overrun flagged
// - FIFO mode read pops receive head
// - Full receive FIFO drops new byte, overrun
// - Written byte sent on serial or IR
// - Non-FIFO write clears holding empty flag
// - Non-FIFO rewrite replaces pending transmit byte
// - FIFO mode accepts sixteen bytes before full
// - Write to full transmit FIFO discarded
module ush_core
    import ush_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [ADDR_W-1:0]   wb_adr_i,
    input  wire logic [DATA_W-1:0]   wb_dat_i,
    output logic      [DATA_W-1:0]   wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic                serial_in,
    input  wire logic                ir_in,
    output logic                     serial_out,
    output logic                     ir_out_n,
    output logic                     irq
);
    import ush_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [1:0] sin_sync_reg;
    logic [1:0] ir_sync_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sin_sync_reg <= 2'h3;
            ir_sync_reg  <= 2'h3;
        end else begin
            sin_sync_reg <= {sin_sync_reg[0], serial_in};
            ir_sync_reg  <= {ir_sync_reg[0], ir_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    function automatic logic is_window(input logic [ADDR_W-1:0] a);
        return (a == SHADOW_WINDOW_11) || (a == SHADOW_WINDOW_12);
    endfunction

    ush_wb_req_t req;
    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                   sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

    wire access   = req.cyc && req.stb && !wb_ack_o;
    wire wr_acc   = access && req.we;
    wire rd_acc   = access && !req.we;
    wire hit_win  = is_window(req.adr);
    wire wr_win   = wr_acc && hit_win && req.sel[0];
    wire rd_win   = rd_acc && hit_win;
    wire wr_fctl  = wr_acc && (req.adr == FIFO_CTRL_ADDR) && req.sel[0];
    wire wr_iclr  = wr_acc && (req.adr == INT_CLR_ADDR) && req.sel[0];
    wire wr_ien   = wr_acc && (req.adr == INT_EN_ADDR) && req.sel[0];

    ////////////////////////////////////////////////////////////////////////////
    // Control
    logic [1:0] fctl_reg;
    wire        fifo_en = fctl_reg[FIFO_EN_BIT];
    wire        ir_mode = fctl_reg[IR_MODE_BIT];
    wire        fifo_toggle = wr_fctl && (req.dat[FIFO_EN_BIT] != fifo_en);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fctl_reg <= '0;
        end else if (wr_fctl) begin
            fctl_reg <= req.dat[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial engine
    ush_byte_t rx_byte;
    ush_byte_t tx_byte;
    logic      tx_ready;
    logic      tx_line;
    wire       rx_line = ir_mode ? ir_sync_reg[1] : sin_sync_reg[1];

    ush_serial u_serial (
        .clk      (clk),
        .rst_n    (rst_n),
        .rx_line  (rx_line),
        .tx_in    (tx_byte),
        .tx_ready (tx_ready),
        .tx_line  (tx_line),
        .rx_out   (rx_byte)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Receive path
    logic [BYTE_W-1:0] rbr_reg;
    logic              rbr_full_reg;
    logic [BYTE_W-1:0] rxf_head;
    logic              rxf_empty;
    logic              rxf_full;
    logic              ovr_reg;

    wire rxf_pop  = rd_win && fifo_en;
    wire rx_drop  = rx_byte.valid && fifo_en && rxf_full && !rxf_pop;
    wire rx_over  = rx_byte.valid && !fifo_en && rbr_full_reg && !rd_win;
    wire data_rdy = fifo_en ? !rxf_empty : rbr_full_reg;
    wire ovr_ev   = rx_drop || rx_over;

    ush_fifo u_rx_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .clr       (fifo_toggle),
        .push      (rx_byte.valid && fifo_en && (!rxf_full || rxf_pop)),
        .push_data (rx_byte.data),
        .pop       (rxf_pop),
        .head      (rxf_head),
        .empty     (rxf_empty),
        .full      (rxf_full)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rbr_reg      <= BYTE_RST;
            rbr_full_reg <= 1'b0;
        end else if (rx_byte.valid && !fifo_en) begin
            rbr_reg      <= rx_byte.data;
            rbr_full_reg <= 1'b1;
        end else if (rd_win && !fifo_en) begin
            rbr_full_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit path
    logic [BYTE_W-1:0] thr_reg;
    logic              thr_full_reg;
    logic [BYTE_W-1:0] txf_head;
    logic              txf_empty;
    logic              txf_full;

    wire tx_take  = tx_ready && (fifo_en ? !txf_empty : thr_full_reg);
    wire transmit_holding_empty_flag     = fifo_en ? txf_empty : !thr_full_reg;
    assign tx_byte = '{valid: tx_take, data: fifo_en ? txf_head : thr_reg};

    ush_fifo u_tx_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .clr       (fifo_toggle),
        .push      (wr_win && fifo_en && !txf_full),
        .push_data (req.dat[BYTE_W-1:0]),
        .pop       (tx_take && fifo_en),
        .head      (txf_head),
        .empty     (txf_empty),
        .full      (txf_full)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            thr_reg      <= BYTE_RST;
            thr_full_reg <= 1'b0;
        end else if (wr_win && !fifo_en) begin
            thr_reg      <= req.dat[BYTE_W-1:0];
            thr_full_reg <= 1'b1;
        end else if (tx_take && !fifo_en) begin
            thr_full_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overrun and interrupts
    logic [EV_W-1:0] ist_reg;
    logic [EV_W-1:0] ien_reg;
    logic            transmit_holding_empty_flag_q_reg;
    wire  [EV_W-1:0] ev;
    wire  [EV_W-1:0] clr_mask = wr_iclr ? req.dat[EV_W-1:0] : '0;
    wire  [EV_W-1:0] ist_next = ev | (ist_reg & ~clr_mask);
    wire  [EV_W-1:0] ien_next = wr_ien ? req.dat[EV_W-1:0] : ien_reg;

    assign ev[EV_RX_BIT]   = rx_byte.valid && !ovr_ev;
    assign ev[EV_OVR_BIT]  = ovr_ev;
    assign ev[EV_TRANSMIT_HOLDING_EMPTY_FLAG_BIT] = transmit_holding_empty_flag && !transmit_holding_empty_flag_q_reg;

    // Overrun flag clears on a line status read; a new overrun wins
    wire rd_lsr = rd_acc && (req.adr == LINE_STAT_ADDR);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ovr_reg    <= 1'b0;
            ist_reg    <= '0;
            ien_reg    <= '0;
            transmit_holding_empty_flag_q_reg <= 1'b1;
            irq        <= 1'b0;
        end else begin
            ovr_reg    <= ovr_ev || (ovr_reg && !rd_lsr);
            ist_reg    <= ist_next;
            transmit_holding_empty_flag_q_reg <= transmit_holding_empty_flag;
            irq        <= |(ist_next & ien_next);
            if (wr_ien) begin
                ien_reg <= req.dat[EV_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux and ack
    logic [DATA_W-1:0] lsr_val;
    always_comb begin
        lsr_val = '0;
        lsr_val[LS_DR_BIT]     = data_rdy;
        lsr_val[LS_OVR_BIT]    = ovr_reg;
        lsr_val[LS_TRANSMIT_HOLDING_EMPTY_FLAG_BIT]   = transmit_holding_empty_flag;
        lsr_val[LS_TXFULL_BIT] = txf_full;
    end

    wire [DATA_W-1:0] rd_val =
        hit_win                      ? DATA_W'(fifo_en ? rxf_head : rbr_reg) :
        (req.adr == FIFO_CTRL_ADDR)  ? DATA_W'(fctl_reg) :
        (req.adr == LINE_STAT_ADDR)  ? lsr_val :
        (req.adr == INT_STAT_ADDR)   ? DATA_W'(ist_reg) :
        (req.adr == INT_EN_ADDR)     ? DATA_W'(ien_reg) :
                                       RD_UNMAPPED;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= '0;
            serial_out <= 1'b1;
            ir_out_n   <= 1'b1;
        end else begin
            wb_ack_o   <= access;
            wb_dat_o   <= rd_acc ? rd_val : '0;
            serial_out <= ir_mode ? 1'b1 : tx_line;
            ir_out_n   <= ir_mode ? tx_line : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_ack_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    a_write_clears_transmit_holding_empty_flag: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_win && !fifo_en && !fifo_toggle) |=> !transmit_holding_empty_flag) else $error("transmit_holding_empty_flag not cleared");
    a_rewrite_replace: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_win && !fifo_en && !wr_fctl) |=> thr_reg == $past(req.dat[BYTE_W-1:0]))
        else $error("pending byte not replaced");
    a_full_tx_drop: assert property (@(posedge clk) disable iff (!rst_n)
        (txf_full && !tx_take && !fifo_toggle) |=> txf_full) else $error("full fifo changed");
    a_rx_keep_full: assert property (@(posedge clk) disable iff (!rst_n)
        (rx_drop && !fifo_toggle) |=> (rxf_full && ovr_reg)) else $error("drop lost data");
    a_overrun_flag: assert property (@(posedge clk) disable iff (!rst_n)
        rx_over |=> ovr_reg ##0 rbr_full_reg) else $error("overrun not flagged");
    a_pop_on_read: assert property (@(posedge clk) disable iff (!rst_n)
        (rxf_pop && !rxf_empty && !rx_byte.valid && !fifo_toggle) |=> !rxf_full)
        else $error("read did not pop");
    a_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (wb_ack_o && $past(rd_win)) |-> wb_dat_o[DATA_W-1:BYTE_W] == '0)
        else $error("upper bits set");
    a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
        (irq == |(ist_reg & ien_reg))) else $error("irq mismatch");
    c_fifo_full: cover property (@(posedge clk) txf_full && fifo_en);
    c_overrun: cover property (@(posedge clk) rx_over);
    c_rx_drop: cover property (@(posedge clk) rx_drop);
    c_window_read: cover property (@(posedge clk) rd_win && data_rdy);
    c_ir_tx: cover property (@(posedge clk) ir_mode && !ir_out_n);

    a_ack_after_take: assert property (@(posedge clk) disable iff (!rst_n)
        access |=> wb_ack_o)
        else $error("request not acked");

    a_dat_idle_zero: assert property (@(posedge clk) disable iff (!rst_n)
        !wb_ack_o |-> wb_dat_o == '0)
        else $error("read data outside ack");

    a_sel_guard: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_acc && hit_win && !req.sel[0]) |=> thr_reg == $past(thr_reg))
        else $error("write without lane 0 acted");

    a_plain_read: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_win && !fifo_en) |=> wb_dat_o == DATA_W'($past(rbr_reg)))
        else $error("window read wrong byte");

    a_fifo_read: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_win && fifo_en) |=> wb_dat_o == DATA_W'($past(rxf_head)))
        else $error("fifo head not returned");

    a_rx_ready_set: assert property (@(posedge clk) disable iff (!rst_n)
        (rx_byte.valid && !fifo_en) |=> rbr_full_reg)
        else $error("ready not set");

    a_rx_store: assert property (@(posedge clk) disable iff (!rst_n)
        (rx_byte.valid && !fifo_en) |=> rbr_reg == $past(rx_byte.data))
        else $error("received byte not stored");

    a_read_clears_ready: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_win && !fifo_en && !rx_byte.valid) |=> !rbr_full_reg)
        else $error("ready not cleared");

    a_rx_push: assert property (@(posedge clk) disable iff (!rst_n)
        (rx_byte.valid && fifo_en && !rxf_full && !fifo_toggle) |=> !rxf_empty)
        else $error("received byte not queued");

    a_ovr_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        (ovr_reg && !rd_lsr) |=> ovr_reg)
        else $error("overrun lost");

    a_ovr_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_lsr && !ovr_ev) |=> !ovr_reg)
        else $error("overrun not cleared");

    a_serial_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        ir_mode |=> serial_out)
        else $error("serial line active in ir mode");

    a_ir_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        !ir_mode |=> ir_out_n)
        else $error("ir line active in uart mode");

    a_tx_starts: assert property (@(posedge clk) disable iff (!rst_n)
        tx_take |=> !tx_ready)
        else $error("frame not started");

    a_transmit_holding_empty_flag_returns: assert property (@(posedge clk) disable iff (!rst_n)
        (tx_take && !fifo_en && !wr_win && !wr_fctl) |=> transmit_holding_empty_flag)
        else $error("holding empty not restored");

    a_tx_accept: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_win && fifo_en && !txf_full) |=> !txf_empty)
        else $error("write not queued");

    a_ist_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        !wr_iclr |=> (ist_reg & $past(ist_reg)) == $past(ist_reg))
        else $error("status bit lost");

    a_reset_values: assert property (@(posedge clk)
        !rst_n |=> (!wb_ack_o && !irq && serial_out && ir_out_n &&
                    rbr_reg == BYTE_RST && thr_reg == BYTE_RST))
        else $error("reset values wrong");
endmodule

// >>> hw/ush_fifo.sv
`timescale 1ns/10ps
module ush_fifo
    import ush_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                clr,
    input  wire logic                push,
    input  wire logic [BYTE_W-1:0]   push_data,
    input  wire logic                pop,
    output logic      [BYTE_W-1:0]   head,
    output logic                     empty,
    output logic                     full
);
    logic [BYTE_W-1:0] mem [FIFO_DEPTH];
    logic [PTR_W-1:0]  wr_reg;
    logic [PTR_W-1:0]  rd_reg;
    logic [CNT_W-1:0]  cnt_reg;
    wire               do_pop  = pop && !empty;
    // A push into a full FIFO is taken when the head leaves in the same cycle
    wire               do_push = push && (!full || do_pop);

    assign empty = (cnt_reg == '0);
    assign full  = (cnt_reg == FIFO_FULL_CNT);
    assign head  = mem[rd_reg];

    always_ff @(posedge clk) begin
        if (!rst_n || clr) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (do_push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + CNT_W'(do_push) - CNT_W'(do_pop);
        end
    end

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_reg] <= push_data;
        end
    end
endmodule

// >>> hw/ush_pkg.sv
package ush_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned PTR_W = 4;
    localparam int unsigned CNT_W = 5;
    localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 5'h10;

    // Shadow data windows (byte addresses)
    localparam logic [ADDR_W-1:0] SHADOW_WINDOW_11 = 32'h5000115C;
    localparam logic [ADDR_W-1:0] SHADOW_WINDOW_12 = 32'h50001160;
    // Control and status registers
    localparam logic [ADDR_W-1:0] FIFO_CTRL_ADDR = 32'h50001180;
    localparam logic [ADDR_W-1:0] LINE_STAT_ADDR = 32'h50001184;
    localparam logic [ADDR_W-1:0] INT_STAT_ADDR = 32'h50001188;
    localparam logic [ADDR_W-1:0] INT_CLR_ADDR = 32'h5000118C;
    localparam logic [ADDR_W-1:0] INT_EN_ADDR = 32'h50001190;

    // Field positions
    localparam int unsigned FIFO_EN_BIT = 0;
    localparam int unsigned IR_MODE_BIT = 1;
    localparam int unsigned LS_DR_BIT = 0;
    localparam int unsigned LS_OVR_BIT = 1;
    localparam int unsigned LS_TRANSMIT_HOLDING_EMPTY_FLAG_BIT = 5;
    localparam int unsigned LS_TXFULL_BIT = 6;

    // Interrupt events
    localparam int unsigned EV_W = 3;
    localparam int unsigned EV_RX_BIT = 0;
    localparam int unsigned EV_OVR_BIT = 1;
    localparam int unsigned EV_TRANSMIT_HOLDING_EMPTY_FLAG_BIT = 2;

    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [DATA_W-1:0] RD_UNMAPPED = 32'h00000000;

    // Bus request as seen by the slave
    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [3:0]        sel;
        logic [ADDR_W-1:0] adr;
        logic [DATA_W-1:0] dat;
    } ush_wb_req_t;

    // Byte stream between core and serial engine
    typedef struct packed {
        logic              valid;
        logic [BYTE_W-1:0] data;
    } ush_byte_t;

endpackage

// >>> hw/ush_serial.sv
`timescale 1ns/10ps
module ush_serial
    import ush_pkg::*;
#(
    parameter int unsigned BIT_CYCLES = 16
)(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              rx_line,
    input  ush_pkg::ush_byte_t     tx_in,
    output logic                   tx_ready,
    output logic                   tx_line,
    output ush_pkg::ush_byte_t     rx_out
);
    import ush_pkg::*;
    localparam int unsigned FRAME_BITS = 10;

    // Transmitter: start bit, eight data bits LSB first, stop bit
    logic [FRAME_BITS-1:0] tsh_reg;
    logic [3:0]            tbits_reg;
    logic [15:0]           tdiv_reg;
    wire                   t_tick = (tdiv_reg == 16'(BIT_CYCLES - 1));

    assign tx_ready = (tbits_reg == '0);
    assign tx_line  = tsh_reg[0];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tsh_reg   <= '1;
            tbits_reg <= '0;
            tdiv_reg  <= '0;
        end else if (tx_ready) begin
            tdiv_reg <= '0;
            if (tx_in.valid) begin
                tsh_reg   <= {1'b1, tx_in.data, 1'b0};
                tbits_reg <= 4'(FRAME_BITS);
            end
        end else begin
            tdiv_reg <= t_tick ? '0 : tdiv_reg + 16'h0001;
            if (t_tick) begin
                tsh_reg   <= {1'b1, tsh_reg[FRAME_BITS-1:1]};
                tbits_reg <= tbits_reg - 4'h1;
            end
        end
    end

    // Receiver: sample mid-bit after a falling start edge
    logic [BYTE_W:0] rsh_reg;
    logic [3:0]      rbits_reg;
    logic [15:0]     rdiv_reg;
    wire             r_tick = (rdiv_reg == 16'(BIT_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsh_reg   <= '0;
            rbits_reg <= '0;
            rdiv_reg  <= '0;
            rx_out    <= '0;
        end else begin
            rx_out.valid <= 1'b0;
            if (rbits_reg == '0) begin
                if (!rx_line) begin
                    rbits_reg <= 4'(FRAME_BITS);
                    rdiv_reg  <= 16'(BIT_CYCLES / 2);
                end
            end else begin
                rdiv_reg <= r_tick ? '0 : rdiv_reg + 16'h0001;
                if (r_tick) begin
                    rsh_reg   <= {rx_line, rsh_reg[BYTE_W:1]};
                    rbits_reg <= rbits_reg - 4'h1;
                    if (rbits_reg == 4'h1) begin
                        rx_out.valid <= rx_line;
                        rx_out.data  <= rsh_reg[BYTE_W:1];
                    end
                end
            end
        end
    end
endmodule
